/* File: pbwp_packer.sv */
// pbwp_packer: moves raw packet bytes between a byte stream and word storage.
// Assumes a registered word memory on mclk: mem_rdata is valid in the cycle
// after mem_re is high; a write takes effect on the edge mem_we is high.
`timescale 1ns/1ps
`default_nettype none

module pbwp_packer #(
   parameter int AW = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [AW-1:0] cfg_base_addr,
   input wire logic cfg_variable,
   input wire logic cfg_byte_only,
   input wire logic cfg_swap,
   input wire logic [15:0] cfg_fixed_len,
   input wire logic [15:0] cfg_max_len,
   input wire logic start_send,
   input wire logic start_recv,
   output logic busy,
   output logic done,
   output logic mem_re,
   output logic mem_we,
   output logic [AW-1:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready
);

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------------
   // state and datapath
   // ----------------------------------------------------------------------
   pbwp_pkg::pbwp_state_e state_q;
   logic [AW-1:0] base_q, waddr_q;
   logic [15:0] len_q, cnt_q, buf_q;
   logic [7:0] first_q;
   logic half_q, var_q, byte_only_q, swap_q, len_wr_q, pad_q;
   logic busy_q, done_q, re_q, we_q, txv_q, rxr_q;
   logic [AW-1:0] addr_q;
   logic [15:0] wdata_q;
   logic [7:0] txd_q;

   logic rx_acc, keep, fin, pad_now;
   logic [7:0] pad_src;
   assign rx_acc = rx_valid && rxr_q;
   assign keep = cnt_q < len_q;   // len_q holds the store limit on receive
   assign fin = var_q ? rx_last : (keep && (cnt_q + 16'h0001 == len_q));
   assign pad_now = fin && !byte_only_q && (keep ? !half_q : half_q);
   assign pad_src = keep ? rx_data : first_q;

   // pick the byte that leaves first or second from a stored word
   function automatic logic [7:0] pick(input logic [15:0] w,
                                       input logic upper);
      pick = upper ? w[15:8] : w[7:0];
   endfunction

   // pair two stream bytes into a word in arrival order
   function automatic logic [15:0] pair(input logic [7:0] early,
                                        input logic [7:0] late,
                                        input logic swap);
      pair = swap ? {early, late} : {late, early};
   endfunction

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= pbwp_pkg::S_IDLE;
         base_q <= '0;
         waddr_q <= '0;
         len_q <= pbwp_pkg::WORD_RST;
         cnt_q <= pbwp_pkg::WORD_RST;
         buf_q <= pbwp_pkg::WORD_RST;
         first_q <= pbwp_pkg::BYTE_RST;
         half_q <= 1'b0;
         var_q <= 1'b0;
         byte_only_q <= 1'b0;
         swap_q <= 1'b0;
         len_wr_q <= 1'b0;
         pad_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         re_q <= 1'b0;
         we_q <= 1'b0;
         txv_q <= 1'b0;
         rxr_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= pbwp_pkg::WORD_RST;
         txd_q <= pbwp_pkg::BYTE_RST;
      end else begin
         re_q <= 1'b0;
         we_q <= 1'b0;
         done_q <= 1'b0;
         len_wr_q <= 1'b0;
         pad_q <= 1'b0;
         unique case (state_q)
            pbwp_pkg::S_IDLE: begin
               base_q <= cfg_base_addr;
               var_q <= cfg_variable;
               byte_only_q <= cfg_byte_only;
               swap_q <= cfg_swap;
               cnt_q <= pbwp_pkg::WORD_RST;
               half_q <= 1'b0;
               addr_q <= cfg_base_addr;
               if (start_send) begin
                  busy_q <= 1'b1;
                  len_q <= cfg_fixed_len;
                  re_q <= cfg_variable || (cfg_fixed_len != 16'h0000);
                  if (cfg_variable)
                     state_q <= pbwp_pkg::S_LREQ;
                  else if (cfg_fixed_len == 16'h0000)
                     state_q <= pbwp_pkg::S_DONE;
                  else
                     state_q <= pbwp_pkg::S_RREQ;
               end else if (start_recv) begin
                  busy_q <= 1'b1;
                  len_q <= cfg_variable ? cfg_max_len : cfg_fixed_len;
                  // data follows the length word in variable mode
                  waddr_q <= cfg_variable ?
                     cfg_base_addr + AW'(pbwp_pkg::LEN_HDR_WORDS) :
                     cfg_base_addr;
                  if (!cfg_variable && cfg_fixed_len == 16'h0000) begin
                     state_q <= pbwp_pkg::S_DONE;
                  end else begin
                     rxr_q <= 1'b1;
                     state_q <= pbwp_pkg::S_RX;
                  end
               end
            end
            pbwp_pkg::S_LREQ: state_q <= pbwp_pkg::S_LDAT;
            pbwp_pkg::S_LDAT: begin
               len_q <= mem_rdata;   // byte count
               if (mem_rdata == 16'h0000) begin
                  state_q <= pbwp_pkg::S_DONE;
               end else begin
                  re_q <= 1'b1;
                  addr_q <= base_q + AW'(pbwp_pkg::LEN_HDR_WORDS);
                  state_q <= pbwp_pkg::S_RREQ;
               end
            end
            pbwp_pkg::S_RREQ: state_q <= pbwp_pkg::S_RDAT;
            pbwp_pkg::S_RDAT: begin
               buf_q <= mem_rdata;
               txd_q <= pick(mem_rdata, swap_q && !byte_only_q);
               txv_q <= 1'b1;
               half_q <= 1'b0;
               state_q <= pbwp_pkg::S_TX;
            end
            pbwp_pkg::S_TX: begin
               if (tx_ready) begin
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q + 16'h0001 == len_q) begin
                     // odd tail: second half never leaves
                     txv_q <= 1'b0;
                     state_q <= pbwp_pkg::S_DONE;
                  end else if (!byte_only_q && !half_q) begin
                     txd_q <= pick(buf_q, !swap_q);
                     half_q <= 1'b1;
                  end else begin
                     // one-byte mode takes the next word per byte
                     txv_q <= 1'b0;
                     re_q <= 1'b1;
                     addr_q <= addr_q + AW'(1);
                     state_q <= pbwp_pkg::S_RREQ;
                  end
               end
            end
            pbwp_pkg::S_RX: begin
               if (rx_acc) begin
                  if (keep)
                     cnt_q <= cnt_q + 16'h0001;   // excess dropped
                  if (pad_now) begin
                     we_q <= 1'b1;
                     pad_q <= 1'b1;
                     addr_q <= waddr_q;
                     wdata_q <= pair(pad_src, pbwp_pkg::PAD_BYTE,
                                     swap_q);
                  end else if (keep && byte_only_q) begin
                     we_q <= 1'b1;
                     addr_q <= waddr_q;
                     waddr_q <= waddr_q + AW'(1);
                     wdata_q <= {pbwp_pkg::PAD_BYTE, rx_data};
                  end else if (keep && half_q) begin
                     we_q <= 1'b1;
                     addr_q <= waddr_q;
                     waddr_q <= waddr_q + AW'(1);
                     half_q <= 1'b0;
                     wdata_q <= pair(first_q, rx_data, swap_q);
                  end else if (keep) begin
                     first_q <= rx_data;
                     half_q <= 1'b1;
                  end
                  if (fin) begin
                     rxr_q <= 1'b0;
                     state_q <= var_q ? pbwp_pkg::S_LEN : pbwp_pkg::S_DONE;
                  end
               end
            end
            pbwp_pkg::S_LEN: begin
               we_q <= 1'b1;
               len_wr_q <= 1'b1;
               addr_q <= base_q;
               wdata_q <= cnt_q;          // stored bytes
               state_q <= pbwp_pkg::S_DONE;
            end
            pbwp_pkg::S_DONE: begin
               // truncation is not an error
               done_q <= 1'b1;
               busy_q <= 1'b0;
               state_q <= pbwp_pkg::S_IDLE;
            end
            default: state_q <= pbwp_pkg::S_IDLE;
         endcase
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign mem_re = re_q;
   assign mem_we = we_q;
   assign mem_addr = addr_q;
   assign mem_wdata = wdata_q;
   assign tx_valid = txv_q;
   assign tx_data = txd_q;
   assign rx_ready = rxr_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   logic [AW-1:0] data_base;
   logic [15:0] woff;
   assign data_base = base_q + AW'(var_q);
   assign woff = byte_only_q ? cnt_q - 16'h0001 :
                 ((cnt_q + 16'h0001) >> 1) - 16'h0001;

   a_fixed_base: assert property (@(posedge mclk) disable iff (!rst_n_q)
      (state_q == pbwp_pkg::S_IDLE && start_send && !cfg_variable &&
       cfg_fixed_len != 16'h0000)
      |=> re_q && addr_q == $past(cfg_base_addr))
      else $error("fixed send did not start at base word");
   a_len_word_base: assert property (@(posedge mclk) disable iff (!rst_n_q)
      state_q == pbwp_pkg::S_LEN |=> we_q && addr_q == base_q)
      else $error("length word not written at base");
   a_len_in_bytes: assert property (@(posedge mclk) disable iff (!rst_n_q)
      state_q == pbwp_pkg::S_LEN |=> wdata_q == $past(cnt_q))
      else $error("length word is not the byte count");
   a_low_byte_only: assert property (@(posedge mclk) disable iff (!rst_n_q)
      we_q && byte_only_q && !len_wr_q |-> wdata_q[15:8] == 8'h00)
      else $error("one-byte mode wrote upper byte");
   a_pad_zero: assert property (@(posedge mclk) disable iff (!rst_n_q)
      pad_q |-> (swap_q ? wdata_q[7:0] : wdata_q[15:8]) == 8'h00)
      else $error("odd tail not zero padded");
   a_trunc_limit: assert property (@(posedge mclk) disable iff (!rst_n_q)
      state_q == pbwp_pkg::S_RX |-> cnt_q <= len_q)
      else $error("stored past maximum length");
   a_send_bound: assert property (@(posedge mclk) disable iff (!rst_n_q)
      state_q == pbwp_pkg::S_TX |-> cnt_q < len_q && txv_q)
      else $error("sent more bytes than field length");
   a_pair_second: assert property (@(posedge mclk) disable iff (!rst_n_q)
      (state_q == pbwp_pkg::S_TX && tx_ready && !byte_only_q && !half_q &&
       cnt_q + 16'h0001 != len_q)
      |=> txv_q && txd_q == (swap_q ? $past(buf_q[7:0]) :
                             $past(buf_q[15:8])))
      else $error("second byte of word not sent next");
   a_first_byte: assert property (@(posedge mclk) disable iff (!rst_n_q)
      state_q == pbwp_pkg::S_RDAT && !byte_only_q
      |=> txd_q == (swap_q ? $past(mem_rdata[15:8]) :
                    $past(mem_rdata[7:0])))
      else $error("first byte taken from wrong half");
   a_packed_addr: assert property (@(posedge mclk) disable iff (!rst_n_q)
      we_q && !len_wr_q && !byte_only_q
      |-> addr_q == data_base + AW'(woff))
      else $error("packed word at wrong address");
   a_byte_addr: assert property (@(posedge mclk) disable iff (!rst_n_q)
      we_q && !len_wr_q && byte_only_q
      |-> addr_q == data_base + AW'(woff))
      else $error("byte word at wrong address");

endmodule

`default_nettype wire

/* File: pbwp_pkg.sv */
// pbwp_pkg: shared constants and state encoding for the packet byte/word
// packer. Assumes 16-bit storage words and byte-wide packet streams.
package pbwp_pkg;

   // ----------------------------------------------------------------------
   // widths and fill values
   // ----------------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // data follows the length word by this many words in variable mode
   localparam logic [15:0] LEN_HDR_WORDS = 16'h0001;

   // ----------------------------------------------------------------------
   // controller states, gray code in the order listed
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_LREQ = 4'h1,
      S_LDAT = 4'h3,
      S_RREQ = 4'h2,
      S_RDAT = 4'h6,
      S_TX   = 4'h7,
      S_DONE = 4'h5,
      S_RX   = 4'h4,
      S_LEN  = 4'hC
   } pbwp_state_e;

endpackage

/* File: pbwp_mem_model.sv */
// pbwp_mem_model: word storage partner for the packer, one-cycle reads.
// Assumes registered strobes on mclk; the bench preloads mem directly.
`timescale 1ns/1ps
`default_nettype none
module pbwp_mem_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:255];
   logic [15:0] rd_q;
   logic rv_q;

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rv_q <= 1'b0;
         rd_q <= 16'h0000;
      end else begin
         rv_q <= mem_re;
         if (mem_re) begin
            rd_q <= mem[mem_addr[7:0]];
         end
      end
   end

   // ---------------------------------------------------------------
   // write port
   // ---------------------------------------------------------------
   // plain always: the bench also preloads this array
   always @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end

   // stale data inverted so a late sample cannot match by luck
   assign mem_rdata = rv_q ? rd_q : ~rd_q;
endmodule
`default_nettype wire

/* File: tb.sv */
// tb: random send and receive runs over every storage mode of the packer.
// Assumes the word memory partner; expectations come from bench functions.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk, resetn, var_f, bo_f, sw_f, st_s, st_r, busy, done, re, we;
   logic txv, txr, rxv, rxl, rxr, took, hung;
   logic [15:0] flen, mlen, rdata, maddr, wdata, m, e;
   logic [7:0] txd, rxd;
   logic [7:0] bs [0:63];
   logic [15:0] snap [0:255];
   integer seed = 32'h6d0c08f4;
   integer bad_count = 0;
   integer total_checks = 0;
   integer base, n, s, off, i, k, t, w, nw;

   pbwp_packer pbwp_packer_inst (.mclk(mclk), .resetn(resetn),
      .cfg_base_addr(base[15:0]), .cfg_variable(var_f),
      .cfg_byte_only(bo_f), .cfg_swap(sw_f), .cfg_fixed_len(flen),
      .cfg_max_len(mlen), .start_send(st_s), .start_recv(st_r),
      .busy(busy), .done(done), .mem_re(re), .mem_we(we),
      .mem_addr(maddr), .mem_wdata(wdata), .mem_rdata(rdata),
      .tx_valid(txv), .tx_data(txd), .tx_ready(txr), .rx_valid(rxv),
      .rx_data(rxd), .rx_last(rxl), .rx_ready(rxr));
   pbwp_mem_model pbwp_mem_model_inst (.mclk(mclk), .resetn(resetn),
      .mem_re(re), .mem_we(we), .mem_addr(maddr), .mem_wdata(wdata),
      .mem_rdata(rdata));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // checking and expectation helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge mclk);
      #2;
   endtask

   function automatic logic [7:0] exp_tx(input integer j);
      logic [15:0] x;
      x = snap[base + off + (bo_f ? j : j / 2)];
      return (!bo_f && (j[0] ^ sw_f)) ? x[15:8] : x[7:0];
   endfunction

   function automatic logic [15:0] exp_word(input integer j);
      logic [7:0] lo, hi;
      if (bo_f) return {8'h00, bs[j]};
      lo = bs[2 * j];
      hi = (2 * j + 1 < s) ? bs[2 * j + 1] : 8'h00;
      return sw_f ? {lo, hi} : {hi, lo};
   endfunction

   // ---------------------------------------------------------------
   // one transfer, dir high for receive
   // ---------------------------------------------------------------
   task automatic run(input logic dir);
      tick();
      for (k = 0; k < 256; k++) begin
         snap[k] = 16'($random(seed));
      end
      off = var_f;
      if (var_f && !dir) snap[base] = 16'(n);
      for (k = 0; k < 256; k++) begin
         pbwp_mem_model_inst.mem[k] = snap[k];
      end
      s = (var_f && dir && n > mlen) ? mlen : n;
      st_s = !dir;
      st_r = dir;
      tick();
      st_s = 1'b0;
      st_r = 1'b0;
      chk("busy_start", 16'(busy), 16'h0001);
      i = 0;
      for (k = 0; k < 3000; k++) begin
         @(negedge mclk);
         took = dir ? (rxv && rxr === 1'b1) : (txv === 1'b1 && txr);
         if (took) begin
            if (dir) bs[i] = rxd;
            else chk("tx_byte", 16'(txd), 16'(exp_tx(i)));
            i++;
         end
         if (done === 1'b1) break;
         tick();
         txr = 1'($random(seed));
         if (!rxv || took) begin
            rxv = dir && i < n && $random(seed);
            rxd = 8'($random(seed));
            rxl = (i == n - 1);
         end
      end
      if (k == 3000) begin
         bad_count++;
         $display("BAD done expected 1 seen none");
         hung = 1'b1;
         return;
      end
      // step back onto the edge grid before the next stimulus
      tick();
      chk("done_pulse", 16'(done), 16'h0000);
      chk("byte_count", 16'(i), 16'(n));
      chk("busy_end", 16'(busy), 16'h0000);
      if (dir) begin
         nw = bo_f ? s : (s + 1) / 2;
         for (k = base - 1; k <= base + off + nw; k++) begin
            w = k - base - off;
            m = pbwp_mem_model_inst.mem[k];
            e = (w >= 0 && w < nw) ? exp_word(w) : snap[k];
            if (var_f && w == -1) e = 16'(s);
            chk("mem_word", m, e);
         end
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      {var_f, bo_f, sw_f, st_s, st_r, txr, rxv, rxl} = 8'h00;
      rxd = 8'h00;
      hung = 1'b0;
      base = 16;
      flen = 16'h0000;
      mlen = 16'h0000;
      repeat (12) @(posedge mclk);
      #2;
      resetn = 1'b1;
      repeat (3) tick();
      // zero, odd, even and random lengths in all eight modes
      for (t = 0; t < 96 && !hung; t++) begin
         {sw_f, bo_f, var_f} = t[2:0];
         k = (t >> 3) % 6;
         n = (k == 5) ? 1 + ($random(seed) & 31) : (k == 4) ? 7 : k;
         // a variable receive ends only on a last byte, so never empty
         if (t >= 48 && var_f && n == 0) n = 1;
         base = 16 + ($random(seed) & 63);
         flen = 16'(n);
         mlen = 16'($random(seed) & 31);
         run(t >= 48);
      end
      final_report();
   end
endmodule
`default_nettype wire
